// File: logic/sdcp_core.sv
// sdram command, mask, select and clock enable pin driver
//
// What this block does
// - cas driven low at clock edge for sdram read or write column phase
// - ras driven low at clock edge when a row address is valid
// - write enable low for write, high for read, while cas active
// - other commands encoded on ras, cas, we per sdram truth table
// - high mask only in cas cycles, inactive on reads, high disables dq
// - high mask set on writes for even single word or 32-bit bus
// - low mask only in cas cycles, inactive on reads
// - low mask set on 64-bit writes of a single odd word
// - select asserted on sdram access or command; only bus master drives it
// - every control output has an identical output-only copy
// - address bit 10 driven on its own pin apart from main bus
// - clock enable places sdram into and out of self-refresh or suspend
// - on host bus request, self-refresh entered before pins are released
`timescale 1ns/1ps
`default_nettype none
module sdcp_core
    import sdcp_pkg::*;
(
    input  wire logic               clock_in,
    input  wire logic               rst_in,
    input  wire sdcp_pkg::sdcp_req_type req_in,
    input  wire logic               bus_32bit_in,
    input  wire logic               is_master_in,
    input  wire logic               suspend_in,
    input  wire logic               host_bus_request_in,
    output logic                    req_ready_out,
    output logic                    host_bus_grant_out,
    output logic                    ras_primary_out,
    output logic                    ras_copy_out,
    output logic                    cas_primary_out,
    output logic                    cas_copy_out,
    output logic                    sdram_write_enable_primary_out,
    output logic                    sdram_write_enable_copy_out,
    output logic                    high_word_mask_primary_out,
    output logic                    high_word_mask_copy_out,
    output logic                    low_word_mask_primary_out,
    output logic                    low_word_mask_copy_out,
    output logic                    sdram_select_primary_out,
    output logic                    sdram_select_copy_out,
    output logic                    refresh_addr_bit_primary_out,
    output logic                    refresh_addr_bit_copy_out,
    output logic                    sdram_clock_enable_primary_out,
    output logic                    sdram_clock_enable_copy_out,
    output logic                    pins_oe_out
);
    import sdcp_pkg::*;

    // every check below samples on the bus clock and sleeps in reset
    default clocking sdcp_cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    typedef enum logic [2:0] {
        SDCP_RUN     = 3'h1,
        SDCP_SREF    = 3'h2,
        SDCP_GRANTED = 3'h4
    } sdcp_state_type;

    function automatic logic [2:0] sdcp_encode(input logic [2:0] op);
        unique case (op)
            SDCP_OP_ACT:   sdcp_encode = SDCP_CMD_ACT;
            SDCP_OP_READ:  sdcp_encode = SDCP_CMD_RD;
            SDCP_OP_WRITE: sdcp_encode = SDCP_CMD_WR;
            SDCP_OP_PRE:   sdcp_encode = SDCP_CMD_PRE;
            SDCP_OP_REF:   sdcp_encode = SDCP_CMD_REF;
            SDCP_OP_MRS:   sdcp_encode = SDCP_CMD_MRS;
            SDCP_OP_BST:   sdcp_encode = SDCP_CMD_BST;
            default:       sdcp_encode = SDCP_CMD_NOP;
        endcase
    endfunction

    sdcp_state_type state_q;
    sdcp_state_type state_d;
    sdcp_pins_type  pins_q;
    sdcp_pins_type  pins_d;
    logic           oe_q;
    logic           oe_d;
    logic [2:0]     cmd;
    logic           issue;
    logic           is_write;

    always_comb
    begin
        state_d  = state_q;
        pins_d   = pins_q;
        oe_d     = oe_q;
        cmd      = SDCP_CMD_NOP;
        issue    = 1'b0;
        is_write = 1'b0;
        unique case (state_q)
            SDCP_RUN:
            begin
                oe_d  = is_master_in;
                // refused during a host request, so a10 is not disturbed
                issue = req_in.valid && is_master_in &&
                    !host_bus_request_in;
                if (issue)
                begin
                    cmd      = sdcp_encode(req_in.op);
                    is_write = req_in.op == SDCP_OP_WRITE;
                end
                // ras, cas, we from the command table
                pins_d.ras_n = cmd[2];
                pins_d.cas_n = cmd[1];
                pins_d.we_n  = cmd[0];
                // masks only meaningful in write column cycles
                pins_d.high_mask = is_write && (bus_32bit_in ||
                    (req_in.single_word && !req_in.odd_addr));
                pins_d.low_mask  = is_write && !bus_32bit_in &&
                    req_in.single_word && req_in.odd_addr;
                pins_d.select_n = !(issue && req_in.op != SDCP_OP_NOP);
                pins_d.a10 = issue ? req_in.a10 : pins_q.a10;
                pins_d.cke = !suspend_in;
                if (host_bus_request_in && is_master_in)
                begin
                    // self-refresh: refresh command with cke dropped
                    pins_d.ras_n     = SDCP_CMD_REF[2];
                    pins_d.cas_n     = SDCP_CMD_REF[1];
                    pins_d.we_n      = SDCP_CMD_REF[0];
                    pins_d.select_n  = 1'b0;
                    pins_d.high_mask = 1'b0;
                    pins_d.low_mask  = 1'b0;
                    pins_d.cke       = 1'b0;
                    state_d          = SDCP_SREF;
                end
            end
            SDCP_SREF:
            begin
                // deselect with cke low, pins released at this same edge
                pins_d.ras_n    = 1'b1;
                pins_d.cas_n    = 1'b1;
                pins_d.we_n     = 1'b1;
                pins_d.select_n = 1'b1;
                pins_d.cke      = 1'b0;
                oe_d            = 1'b0;
                state_d         = SDCP_GRANTED;
            end
            SDCP_GRANTED:
            begin
                if (!host_bus_request_in)
                begin
                    // exit self-refresh on regaining the bus
                    oe_d       = is_master_in;
                    pins_d.cke = 1'b1;
                    state_d    = SDCP_RUN;
                end
            end
            default:
                state_d = SDCP_RUN;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_q <= SDCP_RUN;
            oe_q    <= 1'b0;
            pins_q  <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                         high_mask: SDCP_RST_MASK, low_mask: SDCP_RST_MASK,
                         select_n: 1'b1, a10: 1'b0, cke: SDCP_RST_CKE};
        end
        else
        begin
            state_q <= state_d;
            oe_q    <= oe_d;
            pins_q  <= pins_d;
        end
    end

    // copies exist only for drive strength
    assign ras_primary_out                = pins_q.ras_n;
    assign ras_copy_out                   = pins_q.ras_n;
    assign cas_primary_out                = pins_q.cas_n;
    assign cas_copy_out                   = pins_q.cas_n;
    assign sdram_write_enable_primary_out = pins_q.we_n;
    assign sdram_write_enable_copy_out    = pins_q.we_n;
    assign high_word_mask_primary_out     = pins_q.high_mask;
    assign high_word_mask_copy_out        = pins_q.high_mask;
    assign low_word_mask_primary_out      = pins_q.low_mask;
    assign low_word_mask_copy_out         = pins_q.low_mask;
    assign sdram_select_primary_out       = pins_q.select_n;
    assign sdram_select_copy_out          = pins_q.select_n;
    assign refresh_addr_bit_primary_out   = pins_q.a10;
    assign refresh_addr_bit_copy_out      = pins_q.a10;
    assign sdram_clock_enable_primary_out = pins_q.cke;
    assign sdram_clock_enable_copy_out    = pins_q.cke;
    assign pins_oe_out                    = oe_q;
    assign host_bus_grant_out             = state_q == SDCP_GRANTED;
    assign req_ready_out = state_q == SDCP_RUN && !host_bus_request_in;

    // a request that the pins show at the next edge
    logic taken;
    assign taken = req_in.valid && is_master_in && req_ready_out;

    a_read_we_high: assert property (
        taken && req_in.op == SDCP_OP_READ |=>
        !cas_primary_out && sdram_write_enable_primary_out &&
        ras_primary_out)
        else $error("read command not encoded");
    a_write_cmd_low: assert property (
        taken && req_in.op == SDCP_OP_WRITE |=>
        !cas_primary_out && !sdram_write_enable_primary_out)
        else $error("write command not encoded");
    a_act_ras_low: assert property (
        taken && req_in.op == SDCP_OP_ACT |=>
        !ras_primary_out && cas_primary_out)
        else $error("activate not encoded");
    a_refresh_code: assert property (
        taken && req_in.op == SDCP_OP_REF |=>
        !ras_primary_out && !cas_primary_out &&
        sdram_write_enable_primary_out)
        else $error("refresh not encoded");
    a_mask_only_cas: assert property (
        high_word_mask_primary_out || low_word_mask_primary_out |->
        !cas_primary_out && !sdram_write_enable_primary_out)
        else $error("mask outside write column cycle");
    a_high_mask_32: assert property (
        taken && req_in.op == SDCP_OP_WRITE && bus_32bit_in |=>
        high_word_mask_primary_out && !low_word_mask_primary_out)
        else $error("high mask wrong on 32-bit write");
    a_low_mask_odd: assert property (
        taken && req_in.op == SDCP_OP_WRITE && !bus_32bit_in &&
        req_in.single_word && req_in.odd_addr |=>
        low_word_mask_primary_out && !high_word_mask_primary_out)
        else $error("low mask wrong on odd write");
    a_select_cmd: assert property (
        !sdram_select_primary_out |-> $past(is_master_in))
        else $error("select driven by non master");
    a_copies_same: assert property (
        {ras_copy_out, cas_copy_out, sdram_write_enable_copy_out,
         high_word_mask_copy_out, low_word_mask_copy_out,
         sdram_select_copy_out, refresh_addr_bit_copy_out,
         sdram_clock_enable_copy_out} ==
        {ras_primary_out, cas_primary_out, sdram_write_enable_primary_out,
         high_word_mask_primary_out, low_word_mask_primary_out,
         sdram_select_primary_out, refresh_addr_bit_primary_out,
         sdram_clock_enable_primary_out})
        else $error("copy differs from primary");
    a_a10_taken: assert property (
        taken |=> refresh_addr_bit_primary_out == $past(req_in.a10))
        else $error("address bit 10 not taken from request");
    a_cke_follows: assert property (
        state_q == SDCP_RUN && !host_bus_request_in |=>
        sdram_clock_enable_primary_out == !$past(suspend_in))
        else $error("clock enable does not follow suspend");
    a_sref_before_off: assert property (
        $fell(pins_oe_out) && state_q == SDCP_GRANTED |->
        !sdram_clock_enable_primary_out &&
        !$past(ras_primary_out) && !$past(cas_primary_out))
        else $error("bus released without self-refresh");
    a_grant_in_two: assert property (
        state_q == SDCP_RUN && host_bus_request_in && is_master_in |=>
        ##1 host_bus_grant_out)
        else $error("grant late after host request");

    c_write_cycle: cover property (@(posedge clock_in) disable iff (rst_in)
        !cas_primary_out && !sdram_write_enable_primary_out);
    c_masked_high: cover property (@(posedge clock_in) disable iff (rst_in)
        high_word_mask_primary_out);
    c_grant_seen: cover property (@(posedge clock_in) disable iff (rst_in)
        host_bus_grant_out ##1 !host_bus_grant_out);
endmodule
`default_nettype wire

// File: logic/sdcp_pkg.sv
// package for the sdram command pin interface
`default_nettype none
package sdcp_pkg;
    // ras, cas, we command codes (active low)
    localparam logic [2:0] SDCP_CMD_NOP  = 3'h7;
    localparam logic [2:0] SDCP_CMD_ACT  = 3'h3;
    localparam logic [2:0] SDCP_CMD_RD   = 3'h5;
    localparam logic [2:0] SDCP_CMD_WR   = 3'h4;
    localparam logic [2:0] SDCP_CMD_PRE  = 3'h2;
    localparam logic [2:0] SDCP_CMD_REF  = 3'h1;
    localparam logic [2:0] SDCP_CMD_MRS  = 3'h0;
    localparam logic [2:0] SDCP_CMD_BST  = 3'h6;
    // request operations
    localparam logic [2:0] SDCP_OP_NOP   = 3'h0;
    localparam logic [2:0] SDCP_OP_ACT   = 3'h1;
    localparam logic [2:0] SDCP_OP_READ  = 3'h2;
    localparam logic [2:0] SDCP_OP_WRITE = 3'h3;
    localparam logic [2:0] SDCP_OP_PRE   = 3'h4;
    localparam logic [2:0] SDCP_OP_REF   = 3'h5;
    localparam logic [2:0] SDCP_OP_MRS   = 3'h6;
    localparam logic [2:0] SDCP_OP_BST   = 3'h7;
    // reset values of the pins
    localparam logic       SDCP_RST_CKE  = 1'h1;
    localparam logic       SDCP_RST_MASK = 1'h0;

    typedef struct packed {
        logic       valid;
        logic [2:0] op;
        logic       a10;
        logic       single_word;
        logic       odd_addr;
    } sdcp_req_type;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic high_mask;
        logic low_mask;
        logic select_n;
        logic a10;
        logic cke;
    } sdcp_pins_type;
endpackage
`default_nettype wire

// File: tb/sdcp_sdram_model.sv
// behavioural sdram partner that watches the command pins
`timescale 1ns/1ps
`default_nettype none
module sdcp_sdram_model
    import sdcp_pkg::*;
(
    input  wire logic                   clock_in,
    input  wire logic                   rst_in,
    input  wire sdcp_pkg::sdcp_pins_type pins_in,
    input  wire logic                   oe_in,
    output logic                        self_refresh_out
);
    import sdcp_pkg::*;
    sdcp_pins_type wire_level;
    // released pins fall to their pull levels, cke pulled down in self refresh
    assign wire_level = oe_in ? pins_in : sdcp_pins_type'(8'he6);
    // the memory samples only at the rising edge
    always @(posedge clock_in)
    begin
        if (rst_in)
            self_refresh_out <= 1'h0;
        else if (wire_level.cke)
            self_refresh_out <= 1'h0;
        else if (!wire_level.select_n && {wire_level.ras_n, wire_level.cas_n,
                 wire_level.we_n} == SDCP_CMD_REF)
            self_refresh_out <= 1'h1;
    end
endmodule
`default_nettype wire

// File: tb/test_sdcp_core.sv
// self-checking bench for the sdram command pin driver
`timescale 1ns/1ps
`default_nettype none
module test_sdcp_core;
    import sdcp_pkg::*;
    logic          clock_in;
    logic          rst_in;
    sdcp_req_type  req;
    logic          bus_32bit;
    logic          is_master;
    logic          suspend;
    logic          host_req;
    logic          ready;
    logic          grant;
    logic          oe;
    logic          sref;
    wire sdcp_pins_type pp;
    wire sdcp_pins_type pc;
    sdcp_pins_type e;
    logic          e_oe;
    int            st;
    int            i;
    int            n_fail;
    int            n_tests;

    sdcp_core dut (
        .clock_in                       (clock_in),
        .rst_in                         (rst_in),
        .req_in                         (req),
        .bus_32bit_in                   (bus_32bit),
        .is_master_in                   (is_master),
        .suspend_in                     (suspend),
        .host_bus_request_in            (host_req),
        .req_ready_out                  (ready),
        .host_bus_grant_out             (grant),
        .ras_primary_out                (pp.ras_n),
        .ras_copy_out                   (pc.ras_n),
        .cas_primary_out                (pp.cas_n),
        .cas_copy_out                   (pc.cas_n),
        .sdram_write_enable_primary_out (pp.we_n),
        .sdram_write_enable_copy_out    (pc.we_n),
        .high_word_mask_primary_out     (pp.high_mask),
        .high_word_mask_copy_out        (pc.high_mask),
        .low_word_mask_primary_out      (pp.low_mask),
        .low_word_mask_copy_out         (pc.low_mask),
        .sdram_select_primary_out       (pp.select_n),
        .sdram_select_copy_out          (pc.select_n),
        .refresh_addr_bit_primary_out   (pp.a10),
        .refresh_addr_bit_copy_out      (pc.a10),
        .sdram_clock_enable_primary_out (pp.cke),
        .sdram_clock_enable_copy_out    (pc.cke),
        .pins_oe_out                    (oe)
    );

    sdcp_sdram_model mem (
        .clock_in         (clock_in),
        .rst_in           (rst_in),
        .pins_in          (pp),
        .oe_in            (oe),
        .self_refresh_out (sref)
    );

    function automatic logic [2:0] cmd_of(input logic [2:0] op);
        case (op)
            SDCP_OP_ACT:   return SDCP_CMD_ACT;
            SDCP_OP_READ:  return SDCP_CMD_RD;
            SDCP_OP_WRITE: return SDCP_CMD_WR;
            SDCP_OP_PRE:   return SDCP_CMD_PRE;
            SDCP_OP_REF:   return SDCP_CMD_REF;
            SDCP_OP_MRS:   return SDCP_CMD_MRS;
            SDCP_OP_BST:   return SDCP_CMD_BST;
            default:       return SDCP_CMD_NOP;
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clock_in = 1'h0;
        forever #5 clock_in = ~clock_in;
    end

    // reference model: next pin values from inputs seen at the rising edge
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            st = 0;
            e = sdcp_pins_type'(8'he5);
            e_oe = 1'h0;
        end
        else
        begin
            {e.ras_n, e.cas_n, e.we_n} = SDCP_CMD_NOP;
            {e.high_mask, e.low_mask, e.select_n} = 3'h1;
            if (st == 0 && host_req && is_master)
            begin
                // self refresh issued before the pins are released
                {e.ras_n, e.cas_n, e.we_n} = SDCP_CMD_REF;
                e.select_n = 1'h0;
                e.cke = 1'h0;
                st = 1;
            end
            else if (st == 0)
            begin
                e.cke = !suspend;
                e_oe = is_master;
                if (req.valid && is_master)
                begin
                    {e.ras_n, e.cas_n, e.we_n} = cmd_of(req.op);
                    e.select_n = req.op == SDCP_OP_NOP;
                    e.a10 = req.a10;
                    if (req.op == SDCP_OP_WRITE)
                    begin
                        e.high_mask = bus_32bit ||
                            (req.single_word && !req.odd_addr);
                        e.low_mask = !bus_32bit && req.single_word &&
                            req.odd_addr;
                    end
                end
            end
            else if (st == 1)
            begin
                e_oe = 1'h0;
                st = 2;
            end
            else if (!host_req)
            begin
                e.cke = 1'h1;
                e_oe = is_master;
                st = 0;
            end
        end
    end

    initial
    begin
        n_fail = 0;
        n_tests = 0;
        rst_in = 1'h1;
        req = '0;
        {bus_32bit, is_master, suspend, host_req} = 4'h4;
        void'($urandom(32'hd156));
        repeat (3) @(negedge clock_in);
        check(pp, e);
        check({grant, oe}, 2'h0);
        rst_in = 1'h0;
        for (i = 0; i < 700; i++)
        begin
            @(negedge clock_in);
            check(pp, e);
            check(pc, e);
            check({grant, ready, oe}, {st == 2,
                st == 0 && !host_req, e_oe});
            if (st == 2)
                check(sref, 1'h1);
            // random traffic, then suspend, then host request rounds
            req = '{1'($urandom % 8 != 0), 3'($urandom),
                    1'($urandom), 1'($urandom), 1'($urandom)};
            bus_32bit = 1'($urandom);
            is_master = (i >= 400) || ($urandom % 8 != 0);
            suspend = (i >= 400 && i < 450) ? 1'($urandom) : 1'h0;
            if (i >= 400 && i < 450)
                req.valid = 1'h0;
            host_req = (i >= 450) && (i % 12 < 6);
        end
        finish_test();
    end

    initial
    begin
        #50000;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
